/* File: include/pws_stage_map.vh */
// constants for the four-stage power protection supervision block
// assumes a 25 MHz clock and an APB master with 32-bit data
//
// Function
// [RQ1] sample blocking input each program cycle
// [RQ2] pick-up without block raises start, timing
// [RQ3] pick-up under block raises blocked only
// [RQ4] block during start clears start, releases
// [RQ5] blocker must act 5 ms early
// [RQ6] fixed delay characteristic only
// [RQ7] on/off events, per-event buffer selection
// [RQ8] every event carries its time stamp
// [RQ9] clearable start, trip, blocked counters
// [RQ10] four independent, separately named stages
// [RQ11] circular store of last 12 records
// [RQ12] record only on assertion edges
// [RQ13] record holds time, id, powers, group
// [RQ14] remaining trip time, 5 ms steps
// [RQ15] condition: normal, start, trip, blocked
// [RQ16] measured over pick-up ratio, 0.01 pu
// [RQ17] measured over nominal ratio, 0.01 pu
// [RQ18] nominal power in use, 0.001 MVA
// [RQ19] pick-up follows active setting group
// [RQ20] expected operating time, 5 ms steps
// [RQ21] release at 97 or 103 percent
// [RQ22] measurements refreshed every 5 ms
// [RQ23] trip after full uninterrupted start delay
`ifndef PWS_STAGE_MAP_VH
`define PWS_STAGE_MAP_VH
// sizes
`define PWS_NSTG      4
`define PWS_NGRP      8
`define PWS_NREC      12
`define PWS_RECW      4
`define PWS_PWRW      24
`define PWS_TMRW      16
// timing
`define PWS_CLK_HZ    25000000
`define PWS_CYC_MS    5
`define PWS_PRE20_MS  20
`define PWS_PRE200_MS 200
// hysteresis and scaling in percent
`define PWS_PCT       100
`define PWS_HYS_OVR   97
`define PWS_HYS_UND   103
// condition codes
`define PWS_C_NORM    2'h0
`define PWS_C_START   2'h1
`define PWS_C_TRIP    2'h2
`define PWS_C_BLKD    2'h3
// control register fields
`define PWS_F_EN      0
`define PWS_F_UNDER   1
`define PWS_F_MASK    2
`define PWS_F_NOMEXT  8
`define PWS_F_DLY     16
// per-stage register window: base = stage * stride
`define PWS_STG_STR   12'h040
`define PWS_O_CTRL    12'h000
`define PWS_O_STAT    12'h004
`define PWS_O_CNTST   12'h008
`define PWS_O_CNTBK   12'h00C
`define PWS_O_RSET    12'h010
`define PWS_O_RNOM    12'h014
`define PWS_O_THRUSE  12'h018
`define PWS_O_EXPT    12'h01C
// global registers
`define PWS_A_THR     12'h100
`define PWS_A_THREND  12'h17C
`define PWS_A_NOMMAN  12'h180
`define PWS_A_NOMUSE  12'h184
`define PWS_A_CNTCLR  12'h188
`define PWS_A_RECSEL  12'h18C
`define PWS_A_RECTIM  12'h190
`define PWS_A_RECID   12'h194
`define PWS_A_RECP20  12'h198
`define PWS_A_RECFLT  12'h19C
`define PWS_A_RECP200 12'h1A0
`define PWS_A_RECREM  12'h1A4
`define PWS_A_RECHEAD 12'h1A8
// reset values
`define PWS_R_CTRL    32'h0000_0000
`define PWS_R_NOM     24'h00_2710
`endif

/* File: logic/pws_stage.v */
// four-stage power protection supervision: blocking, definite delay,
// events, counters, fault record store and live values over APB
// assumes measured power in 0.001 MVA steps, refreshed by the caller
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "pws_stage_map.vh"
module pws_stage
#(
   parameter CYC_TICKS = (`PWS_CLK_HZ / 1000) * `PWS_CYC_MS
)
(
   // clock and reset
   input  wire        MCLK_I,
   input  wire        RST_I,
   // apb slave
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [11:0] PADDR_I,
   input  wire [31:0] PWDATA_I,
   output reg  [31:0] PRDATA_O,
   output reg         PREADY_O,
   output reg         PSLVERR_O,
   // process inputs
   input  wire [23:0] MEAS_PWR_I,
   input  wire [23:0] NOM_EXT_I,
   input  wire [3:0]  BLOCK_I,
   input  wire [2:0]  SET_GROUP_I,
   input  wire [31:0] TIME_I,
   // stage outputs
   output wire [3:0]  START_O,
   output wire [3:0]  TRIP_O,
   output wire [3:0]  BLOCKED_O,
   // event stream
   output reg         EVT_VLD_O,
   output reg  [4:0]  EVT_CODE_O,
   output reg  [31:0] EVT_TIME_O
);

localparam HDEP = `PWS_PRE200_MS / `PWS_CYC_MS;  // samples back to -200 ms
localparam P20  = `PWS_PRE20_MS / `PWS_CYC_MS;   // samples back to -20 ms

////////////////////////////////////////////////////////////////////////////
// program cycle tick
reg  [31:0] tcnt;                 // cycle divider
reg         tick;                 // one pulse per program cycle
reg  [31:0] ts;                   // time stamp of the current cycle
reg  [2:0]  grp;                  // setting group of the current cycle

// divider and per-cycle captures
always @(posedge MCLK_I)
begin
   if (RST_I)
   begin
      tcnt <= 32'h0;
      tick <= 1'b0;
      ts   <= 32'h0;
      grp  <= 3'h0;
   end
   else
   begin
      tick <= (tcnt == CYC_TICKS - 1);
      if (tcnt == CYC_TICKS - 1)
      begin
         tcnt <= 32'h0;
         ts   <= TIME_I;          // see [RQ8]
         grp  <= SET_GROUP_I;     // see [RQ19]
      end
      else
         tcnt <= tcnt + 32'h1;
   end
end

////////////////////////////////////////////////////////////////////////////
// power history, one sample per cycle
reg  [23:0] hist [0:HDEP];        // hist[0] is the newest sample
integer     h;

// shift on each tick
always @(posedge MCLK_I)
begin
   if (RST_I)
   begin
      for (h = 0; h <= HDEP; h = h + 1)
         hist[h] <= 24'h0;
   end
   else if (tick)
   begin
      hist[0] <= MEAS_PWR_I;      // see [RQ22]
      for (h = 1; h <= HDEP; h = h + 1)
         hist[h] <= hist[h-1];
   end
end

////////////////////////////////////////////////////////////////////////////
// software registers
reg  [31:0] ctrl [0:3];           // per stage control
reg  [23:0] thr  [0:31];          // pick-up per stage and group
reg  [23:0] nom_man;              // manual nominal power
reg  [3:0]  cnt_clr;              // counter clear pulses
reg  [3:0]  rsel;                 // record read index
reg  [31:0] rd_data;              // read value for the current address
reg         rd_err;               // unmapped address
wire        acc  = PSEL_I & PENABLE_I;
wire        fire = acc & PREADY_O;
wire [1:0]  asel = PADDR_I[7:6];
integer     k;

// nominal power in use, shared by all stages
wire [23:0] nom_use = ctrl[0][`PWS_F_NOMEXT] ? NOM_EXT_I : nom_man;

////////////////////////////////////////////////////////////////////////////
// stages
wire [127:0] st_info;             // per stage: remain, block input, cond
wire [127:0] st_rset;             // per stage ratio to pick-up
wire [127:0] st_rnom;             // per stage ratio to nominal
wire [127:0] st_cnt;              // per stage start and trip counts
wire [63:0]  st_cbk;              // per stage blocked counts
wire [95:0]  st_thr;              // per stage power 200 ms before start
wire [31:0]  ev_set;              // edge pulses, 8 slots per stage

genvar s;
generate
for (s = 0; s < `PWS_NSTG; s = s + 1)
begin : g_stg
   reg               pick;        // pick-up with hysteresis
   reg               st;          // start
   reg               tr;          // trip
   reg               bk;          // blocked
   reg               st_p;        // previous start
   reg               tr_p;        // previous trip
   reg               bk_p;        // previous blocked
   reg  [15:0]       rem;         // ticks left to trip
   reg  [23:0]       p200;        // power 200 ms before start
   reg  [23:0]       thu;         // pick-up in use
   reg  [15:0]       c_st;        // start count
   reg  [15:0]       c_tr;        // trip count
   reg  [15:0]       c_bk;        // blocked count
   reg  signed [31:0] r_set;      // meas/set in 0.01 pu
   reg  signed [31:0] r_nom;      // meas/nom in 0.01 pu
   wire [31:0]       cr   = ctrl[s];
   wire [15:0]       dly  = cr[`PWS_F_DLY +: 16];
   wire signed [31:0] m   = {{8{MEAS_PWR_I[23]}}, MEAS_PWR_I};
   wire signed [31:0] t   = {{8{thu[23]}}, thu};
   wire signed [31:0] n   = {8'h00, nom_use};
   wire signed [31:0] m1  = m * `PWS_PCT;
   // pick-up and release with fixed hysteresis, see [RQ21]
   wire              up_o = m > t;
   wire              up_u = m < t;
   wire              rl_o = m1 < t * `PWS_HYS_OVR;
   wire              rl_u = m1 > t * `PWS_HYS_UND;
   wire              und  = cr[`PWS_F_UNDER];
   wire              next_pick = cr[`PWS_F_EN] &
                        (pick ? ~(und ? rl_u : rl_o) : (und ? up_u : up_o));
   wire              blk  = BLOCK_I[s];               // see [RQ1]
   wire              next_st = next_pick & ~blk;      // see [RQ2] [RQ4]
   wire              next_bk = next_pick & blk;       // see [RQ3]

   // protection evaluation once per program cycle
   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         pick  <= 1'b0;
         st    <= 1'b0;
         tr    <= 1'b0;
         bk    <= 1'b0;
         rem   <= 16'h0;
         p200  <= 24'h0;
         r_set <= 32'sh0;
         r_nom <= 32'sh0;
      end
      else if (tick)
      begin
         pick <= next_pick;
         st   <= next_st;
         bk   <= next_bk;
         // ratios, zero divisor reads zero, see [RQ16] [RQ17]
         r_set <= (t == 32'sh0) ? 32'sh0 : m1 / t;
         r_nom <= (n == 32'sh0) ? 32'sh0 : m1 / n;
         if (next_st & ~st)
         begin
            rem  <= dly;                  // fixed delay, see [RQ6]
            p200 <= hist[HDEP - 1];
            tr   <= 1'b0;
         end
         else if (next_st)
         begin
            // uninterrupted start counts down, see [RQ14] [RQ23]
            if (rem == 16'h0)
               tr <= 1'b1;
            else
               rem <= rem - 16'h1;
         end
         else
         begin
            // release resets timing and trip, see [RQ4] [RQ23]
            rem <= dly;
            tr  <= 1'b0;
         end
      end
   end

   // edge history, pick-up in use, counters
   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         st_p <= 1'b0;
         tr_p <= 1'b0;
         bk_p <= 1'b0;
         thu  <= 24'h0;
         c_st <= 16'h0;
         c_tr <= 16'h0;
         c_bk <= 16'h0;
      end
      else
      begin
         st_p <= st;
         tr_p <= tr;
         bk_p <= bk;
         thu  <= thr[s * `PWS_NGRP + grp];           // see [RQ19]
         // an increment in the clear cycle still counts, see [RQ9]
         if (st & ~st_p)
            c_st <= (cnt_clr[s] ? 16'h0 : c_st) + 16'h1;
         else if (cnt_clr[s])
            c_st <= 16'h0;
         if (tr & ~tr_p)
            c_tr <= (cnt_clr[s] ? 16'h0 : c_tr) + 16'h1;
         else if (cnt_clr[s])
            c_tr <= 16'h0;
         if (bk & ~bk_p)
            c_bk <= (cnt_clr[s] ? 16'h0 : c_bk) + 16'h1;
         else if (cnt_clr[s])
            c_bk <= 16'h0;
      end
   end

   // separate on and off events per stage, see [RQ7] [RQ10]
   assign ev_set[s*8 +: 8] = {2'b00, ~bk & bk_p, bk & ~bk_p,
                              ~tr & tr_p, tr & ~tr_p, ~st & st_p, st & ~st_p};
   // condition code, see [RQ15]
   assign st_info[s*32 +: 32] = {rem, 6'h0, blk, 7'h0,
                                 tr ? `PWS_C_TRIP : st ? `PWS_C_START :
                                 bk ? `PWS_C_BLKD : `PWS_C_NORM};
   assign st_rset[s*32 +: 32] = r_set;
   assign st_rnom[s*32 +: 32] = r_nom;
   assign st_cnt[s*32 +: 32]  = {c_tr, c_st};
   assign st_cbk[s*16 +: 16]  = c_bk;
   assign st_thr[s*24 +: 24]  = p200;
   assign START_O[s]          = st;
   assign TRIP_O[s]           = tr;
   assign BLOCKED_O[s]        = bk;
end
endgenerate

////////////////////////////////////////////////////////////////////////////
// event drain and fault record store
reg  [31:0] pend;                 // pending events
reg  [4:0]  pidx;                 // lowest pending slot
reg  [31:0] r_tim [0:11];         // record time stamp
reg  [7:0]  r_id  [0:11];         // group and event identity
reg  [23:0] r_p20 [0:11];         // power -20 ms
reg  [23:0] r_flt [0:11];         // power at the event
reg  [23:0] r_p2h [0:11];         // power -200 ms before start
reg  [15:0] r_rem [0:11];         // time left to trip
reg  [3:0]  wptr;                 // next record slot
reg  [3:0]  rcnt;                 // records held
integer     q;
wire [1:0]  ps   = pidx[4:3];
wire [2:0]  pk   = pidx[2:0];
wire [31:0] pinf = st_info[ps*32 +: 32];

// lowest set pending slot
always @*
begin
   pidx = 5'h0;
   for (q = 31; q >= 0; q = q - 1)
      if (pend[q])
         pidx = q[4:0];
end

// one event per clock, records on assertion edges only
always @(posedge MCLK_I)
begin
   if (RST_I)
   begin
      pend       <= 32'h0;
      wptr       <= 4'h0;
      rcnt       <= 4'h0;
      EVT_VLD_O  <= 1'b0;
      EVT_CODE_O <= 5'h0;
      EVT_TIME_O <= 32'h0;
   end
   else
   begin
      // new edges win over the slot being drained
      pend      <= (pend & ~(32'h1 << pidx)) | ev_set;
      EVT_VLD_O <= (pend != 32'h0) & ctrl[ps][`PWS_F_MASK + pk];  // see [RQ7]
      EVT_CODE_O <= pidx;
      EVT_TIME_O <= ts;                                           // see [RQ8]
      if ((pend != 32'h0) & ~pk[0])                               // see [RQ12]
      begin
         // see [RQ13]
         r_tim[wptr] <= ts;
         r_id[wptr]  <= {grp, pidx};
         r_p20[wptr] <= hist[P20];
         r_flt[wptr] <= hist[0];
         r_p2h[wptr] <= st_thr[ps*24 +: 24];
         r_rem[wptr] <= pinf[31:16];
         // circular, oldest overwritten, see [RQ11]
         wptr <= (wptr == `PWS_NREC - 1) ? 4'h0 : wptr + 4'h1;
         if (rcnt != `PWS_NREC)
            rcnt <= rcnt + 4'h1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// apb write side and handshake
always @(posedge MCLK_I)
begin
   if (RST_I)
   begin
      for (k = 0; k < `PWS_NSTG; k = k + 1)
         ctrl[k] <= `PWS_R_CTRL;
      for (k = 0; k < 32; k = k + 1)
         thr[k] <= 24'h0;
      nom_man   <= `PWS_R_NOM;
      cnt_clr   <= 4'h0;
      rsel      <= 4'h0;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0;
   end
   else
   begin
      PREADY_O  <= acc & ~PREADY_O;
      PSLVERR_O <= acc & ~PREADY_O & rd_err;
      PRDATA_O  <= (acc & ~PREADY_O & ~PWRITE_I) ? rd_data : 32'h0;
      cnt_clr   <= 4'h0;
      if (fire & PWRITE_I & ~rd_err)
      begin
         if (PADDR_I < `PWS_A_THR && PADDR_I[5:0] == `PWS_O_CTRL)
            ctrl[asel] <= PWDATA_I;
         else if (PADDR_I >= `PWS_A_THR && PADDR_I <= `PWS_A_THREND)
            thr[PADDR_I[6:2]] <= PWDATA_I[23:0];
         else if (PADDR_I == `PWS_A_NOMMAN)
            nom_man <= PWDATA_I[23:0];
         else if (PADDR_I == `PWS_A_CNTCLR)
            cnt_clr <= PWDATA_I[3:0];                             // see [RQ9]
         else if (PADDR_I == `PWS_A_RECSEL)
            rsel <= (PWDATA_I[3:0] < `PWS_NREC) ? PWDATA_I[3:0] : 4'h0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// apb read decode
wire [5:0]  aoff = PADDR_I[5:0];

// address decode, read values
always @*
begin
   rd_data = 32'h0;
   rd_err  = 1'b0;
   if (PADDR_I < `PWS_A_THR)
   begin
      case (aoff)
         `PWS_O_CTRL:   rd_data = ctrl[asel];
         `PWS_O_STAT:   rd_data = st_info[asel*32 +: 32];         // see [RQ14]
         `PWS_O_CNTST:  rd_data = st_cnt[asel*32 +: 32];
         `PWS_O_CNTBK:  rd_data = {16'h0, st_cbk[asel*16 +: 16]};
         `PWS_O_RSET:   rd_data = st_rset[asel*32 +: 32];
         `PWS_O_RNOM:   rd_data = st_rnom[asel*32 +: 32];
         `PWS_O_THRUSE: rd_data = {8'h0, thr[{asel, grp}]};        // see [RQ19]
         `PWS_O_EXPT:   rd_data = {16'h0, ctrl[asel][`PWS_F_DLY +: 16]}; // see [RQ20]
         default:       rd_err  = 1'b1;
      endcase
   end
   else if (PADDR_I <= `PWS_A_THREND)
      rd_data = {8'h0, thr[PADDR_I[6:2]]};
   else
   begin
      case (PADDR_I)
         `PWS_A_NOMMAN:  rd_data = {8'h0, nom_man};
         `PWS_A_NOMUSE:  rd_data = {8'h0, nom_use};               // see [RQ18]
         `PWS_A_CNTCLR:  rd_data = 32'h0;
         `PWS_A_RECSEL:  rd_data = {28'h0, rsel};
         `PWS_A_RECTIM:  rd_data = r_tim[rsel];
         `PWS_A_RECID:   rd_data = {24'h0, r_id[rsel]};
         `PWS_A_RECP20:  rd_data = {8'h0, r_p20[rsel]};
         `PWS_A_RECFLT:  rd_data = {8'h0, r_flt[rsel]};
         `PWS_A_RECP200: rd_data = {8'h0, r_p2h[rsel]};
         `PWS_A_RECREM:  rd_data = {16'h0, r_rem[rsel]};
         `PWS_A_RECHEAD: rd_data = {24'h0, rcnt, wptr};
         default:        rd_err  = 1'b1;
      endcase
   end
end

endmodule
`default_nettype wire

/* File: tb/pws_stage_properties.sv */
// checker for the power stage supervision block, bound to its top ports
// assumes status outputs move only one clock after a program tick
`timescale 1ns/10ps
`default_nettype none
module pws_stage_properties
#(
   parameter CYC_TICKS = 64
)
(
   // clock and reset
   input wire        MCLK_I,
   input wire        RST_I,
   // stage outputs
   input wire [3:0]  START_O,
   input wire [3:0]  TRIP_O,
   input wire [3:0]  BLOCKED_O,
   // event stream
   input wire        EVT_VLD_O,
   input wire [4:0]  EVT_CODE_O,
   input wire [31:0] EVT_TIME_O
);
   ////////////////////////////////////////////////////////////////////////////
   wire  [11:0] st = {BLOCKED_O, TRIP_O, START_O}; // all status levels
   logic [11:0] st_q;                              // levels one clock ago
   logic [31:0] gap;                               // clocks since last change
   wire         chg = (st != st_q);                // any status moved
   wire  [2:0]  lvl = {BLOCKED_O[EVT_CODE_O[4:3]], TRIP_O[EVT_CODE_O[4:3]],
                       START_O[EVT_CODE_O[4:3]]};  // levels of the event stage
   // spacing counter, saturates at one program cycle
   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         st_q <= 12'h000;
         gap  <= CYC_TICKS;
      end
      else
      begin
         st_q <= st;
         if (chg)
            gap <= 1;
         else if (gap < CYC_TICKS)
            gap <= gap + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);
   property p_excl; (START_O & BLOCKED_O) == 4'h0; endproperty
   a_excl: assert property (p_excl) else $error("start and blocked together");
   property p_trip_in; (TRIP_O & ~START_O) == 4'h0; endproperty
   a_trip_in: assert property (p_trip_in) else $error("trip without start");
   property p_trip_rise; (TRIP_O & ~$past(TRIP_O) & ~$past(START_O)) == 4'h0; endproperty
   a_trip_rise: assert property (p_trip_rise) else $error("trip rose unstarted");
   property p_tick; chg |-> gap == CYC_TICKS; endproperty
   a_tick: assert property (p_tick) else $error("status moved off tick");
   property p_evt_win; EVT_VLD_O |-> (gap >= 2 && gap <= 40); endproperty
   a_evt_win: assert property (p_evt_win) else $error("event outside drain");
   property p_evt_kind; EVT_VLD_O |-> EVT_CODE_O[2:0] <= 3'h5; endproperty
   a_evt_kind: assert property (p_evt_kind) else $error("bad event kind");
   property p_evt_lvl; EVT_VLD_O |-> lvl[EVT_CODE_O[2:1]] == ~EVT_CODE_O[0]; endproperty
   a_evt_lvl: assert property (p_evt_lvl) else $error("event level wrong");
   property p_stamp; EVT_VLD_O && $past(EVT_VLD_O) |-> $stable(EVT_TIME_O); endproperty
   a_stamp: assert property (p_stamp) else $error("stamp moved in burst");
endmodule
bind pws_stage pws_stage_properties #(.CYC_TICKS(CYC_TICKS)) i_pws_stage_properties (
   .MCLK_I(MCLK_I), .RST_I(RST_I), .START_O(START_O), .TRIP_O(TRIP_O),
   .BLOCKED_O(BLOCKED_O), .EVT_VLD_O(EVT_VLD_O), .EVT_CODE_O(EVT_CODE_O),
   .EVT_TIME_O(EVT_TIME_O));
`default_nettype wire

/* File: tb/test_pws_stage.sv */
// self-checking bench for the power stage supervision block
// assumes one apb wait state and a 64-clock program cycle
`timescale 1ns/10ps
`default_nettype none
`include "pws_stage_map.vh"
module test_pws_stage;
   localparam TK = 64;                  // clocks per program cycle
   logic        mclk, rst, psel, pen, power_stage_block, prdy, perr, evv, e;
   logic [11:0] paddr;
   logic [31:0] pwd, prd, tim, evt, r1, r2;
   logic [23:0] meas, nomx;
   logic [3:0]  blk, st, tr, bk;
   logic [2:0]  grp;
   logic [4:0]  evc;
   logic [4:0]  ev_code [0:15];         // logged event codes
   logic [31:0] ev_time [0:15];         // logged event stamps
   logic [4:0]  ev_exp  [0:8] = '{5'h00, 5'h02, 5'h01, 5'h03, 5'h14, 5'h00, 5'h01, 5'h04, 5'h05};
   wire  [11:0] stv = {bk, tr, st};     // status by index
   int          nev = 0, errors = 0, total_checks = 0, n, k;
   pws_stage #(.CYC_TICKS(TK)) i_pws_stage (.MCLK_I(mclk), .RST_I(rst), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(power_stage_block), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd),
      .PREADY_O(prdy), .PSLVERR_O(perr), .MEAS_PWR_I(meas), .NOM_EXT_I(nomx),
      .BLOCK_I(blk), .SET_GROUP_I(grp), .TIME_I(tim), .START_O(st), .TRIP_O(tr),
      .BLOCKED_O(bk), .EVT_VLD_O(evv), .EVT_CODE_O(evc), .EVT_TIME_O(evt));
   initial mclk = 1'b0;
   always #20 mclk = ~mclk;
   // event logger
   always @(posedge mclk)
      if (evv === 1'b1 && nev < 16)
      begin
         ev_code[nev] <= evc;
         ev_time[nev] <= evt;
         nev          <= nev + 1;
      end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic er);
      int i;
      @(posedge mclk);
      psel  <= 1'b1;
      power_stage_block   <= w;
      paddr <= a;
      pwd   <= d;
      @(posedge mclk);
      pen <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge mclk);
         if (prdy === 1'b1)
            break;
      end
      r = prd;
      er = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
      if (i == 20)
      begin
         errors++;
         close_out();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        er;
      apb(1'b1, a, d, r, er);
      check("wr_err", {31'h0, er}, 32'h0);
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
      apb(1'b0, a, 32'h0, r1, e);
      check(nm, r1 & m, exp);
   endtask
   // bounded wait on one status bit, sampled at the falling edge
   task automatic wait_bit(input int idx, input logic v, output int cnt);
      for (cnt = 0; cnt < 2000; cnt++)
      begin
         @(negedge mclk);
         if (stv[idx] === v)
            break;
      end
      if (cnt == 2000)
      begin
         errors++;
         close_out();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst, psel, pen, power_stage_block, paddr, pwd, meas, blk, grp} = {1'b1, 78'h0};
      nomx = 24'h003A98;
      tim  = 32'h0000_0A01;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      // reset values and an unmapped place
      rd("ctrl0", `PWS_O_CTRL, 32'hFFFFFFFF, `PWS_R_CTRL);
      rd("nom_man", `PWS_A_NOMMAN, 32'h00FFFFFF, {8'h0, `PWS_R_NOM});
      rd("cond_norm", `PWS_O_STAT, 32'h3, {30'h0, `PWS_C_NORM});
      apb(1'b0, 12'h1FC, 32'h0, r1, e);
      check("slverr", {31'h0, e}, 32'h1);
      check("unmapped", r1, 32'h0);
      // pick-up follows the setting group
      wr(`PWS_A_THR, 32'h3E8);
      wr(`PWS_A_THR + 12'h004, 32'h7D0);
      wr(`PWS_A_THR + 12'h040, 32'h3E8);
      grp <= 3'h1;
      repeat (2 * TK) @(posedge mclk);
      rd("thr_g1", `PWS_O_THRUSE, 32'hFFFFFF, 32'h7D0);
      grp <= 3'h0;
      repeat (2 * TK) @(posedge mclk);
      rd("thr_g0", `PWS_O_THRUSE, 32'hFFFFFF, 32'h3E8);
      // over-power start and definite delay of two steps
      wr(`PWS_O_CTRL, 32'h0002_01FD);
      rd("nom_use", `PWS_A_NOMUSE, 32'hFFFFFF, 32'h3A98);
      meas <= 24'h0005DC;
      wait_bit(0, 1'b1, n);
      wait_bit(4, 1'b1, n);
      check("trip_delay", n, 3 * TK - 1);
      rd("cond_trip", `PWS_O_STAT, 32'h3, {30'h0, `PWS_C_TRIP});
      rd("exp_time", `PWS_O_EXPT, 32'hFFFF, 32'h2);
      rd("meas_set", `PWS_O_RSET, 32'hFFFF, 32'h96);
      rd("meas_nom", `PWS_O_RNOM, 32'hFFFF, 32'hA);
      // release band holds, then start and trip drop together
      meas <= 24'h0003D4;
      repeat (3 * TK) @(posedge mclk);
      @(negedge mclk);
      check("hold", {28'h0, st}, 32'h1);
      @(posedge mclk);
      meas <= 24'h0003C0;
      wait_bit(0, 1'b0, n);
      check("trip_rel", {28'h0, tr}, 32'h0);
      // stage 2 blocked before pick-up, off event masked
      wr(`PWS_O_CTRL, 32'h0);
      tim <= 32'h0000_0B02;
      blk <= 4'h4;
      wr(`PWS_STG_STR * 2, 32'h0000_0055);
      repeat (2 * TK) @(posedge mclk);
      meas <= 24'h0005DC;
      wait_bit(10, 1'b1, n);
      check("no_start", {28'h0, st}, 32'h0);
      rd("cond_blk", `PWS_STG_STR * 2 + `PWS_O_STAT, 32'h3, {30'h0, `PWS_C_BLKD});
      meas <= 24'h0;
      wait_bit(10, 1'b0, n);
      @(posedge mclk);
      blk <= 4'h0;
      wr(`PWS_STG_STR * 2, 32'h0);
      // long delay: countdown, then block during start
      wr(`PWS_O_CTRL, 32'h0064_01FD);
      meas <= 24'h0005DC;
      wait_bit(0, 1'b1, n);
      rd("cond_start", `PWS_O_STAT, 32'h3, {30'h0, `PWS_C_START});
      apb(1'b0, `PWS_O_STAT, 32'h0, r2, e);
      repeat (2 * TK - 3) @(posedge mclk);
      apb(1'b0, `PWS_O_STAT, 32'h0, r1, e);
      check("remain", {16'h0, r2[31:16] - r1[31:16]}, 32'h2);
      blk <= 4'h1; // well ahead of the delay
      wait_bit(0, 1'b0, n);
      check("blk_after", {28'h0, bk}, 32'h1);
      check("no_trip", {28'h0, tr}, 32'h0);
      @(posedge mclk);
      meas <= 24'h0;
      wait_bit(8, 1'b0, n);
      repeat (TK) @(posedge mclk);
      // events, stamps, counters and records
      check("ev_count", nev, 9);
      for (k = 0; k < 9; k++)
         check("ev_code", {27'h0, ev_code[k]}, {27'h0, ev_exp[k]});
      check("ev_stamp", ev_time[0], 32'hA01);
      check("ev_stamp2", ev_time[4], 32'hB02);
      rd("cnt_st0", `PWS_O_CNTST, 32'hFFFFFFFF, 32'h0001_0002);
      rd("cnt_bk2", `PWS_STG_STR * 2 + `PWS_O_CNTBK, 32'hFFFF, 32'h1);
      wr(`PWS_A_CNTCLR, 32'h1);
      rd("cnt_clr", `PWS_O_CNTST, 32'hFFFFFFFF, 32'h0);
      rd("cnt_bk2b", `PWS_STG_STR * 2 + `PWS_O_CNTBK, 32'hFFFF, 32'h1);
      rd("head", `PWS_A_RECHEAD, 32'hFF, 32'h55);
      wr(`PWS_A_RECSEL, 32'h1);
      rd("rec_id", `PWS_A_RECID, 32'hFF, 32'h02);
      rd("rec_flt", `PWS_A_RECFLT, 32'hFFFFFF, 32'h5DC);
      rd("rec_tim", `PWS_A_RECTIM, 32'hFFFFFFFF, 32'hA01);
      wr(`PWS_A_RECSEL, 32'h2);
      rd("rec_id2", `PWS_A_RECID, 32'hFF, 32'h14);
      // eight more blocked records wrap the store
      for (k = 0; k < 8; k++)
      begin
         @(posedge mclk);
         meas <= 24'h0005DC;
         wait_bit(8, 1'b1, n);
         @(posedge mclk);
         meas <= 24'h0;
         wait_bit(8, 1'b0, n);
      end
      rd("head_wrap", `PWS_A_RECHEAD, 32'hFF, 32'hC1);
      wr(`PWS_A_RECSEL, 32'h0);
      rd("rec_new", `PWS_A_RECID, 32'hFF, 32'h04);
      rd("cnt_bk0", `PWS_O_CNTBK, 32'hFFFF, 32'h8);
      close_out();
   end
endmodule
`default_nettype wire
